// file: common/tx_mod_defs.vh
// Constants for the transmit modulator control register bank.
// Assumes inclusion by bare name from design files; definitions only.
//
// Notes on behaviour
// RULE1: Power-up values: main divider 9750, reference divider 0x4050, control 0x197d.
// RULE2: Control bit 0 is run; low powers down all but serial and registers; code gates only block enables, bypass and trim mode with it.
// RULE3: Control bit 1 keeps filters powered while idle pin is low.
// RULE4: Host keeps control bit 2 at one on every write.
// RULE5: Control bit 3 enables baseband filters; zero selects bypass. Code uses it for bypass only; filter enable ignores it.
// RULE6: Control bit 4 enables the RF PLL.
// RULE7: Control bit 5 enables the RF oscillator.
// RULE8: Control bit 6 enables driver, upconverter and IF modulator together.
// RULE9: Control bit 7 enables reference doubler ahead of reference divider.
// RULE10: Control bit 8 selects maximum power, one high level, zero low.
// RULE11: Control bit 9 sets predriver bias, zero reduced, one nominal.
// RULE12: Control bit 10 sets output bias, zero nominal, one raised.
// RULE13: Control bits 12:11 choose charge-pump current, reset 11.
// RULE14: Control bits 14:13 set offset current, effective only in trim mode.
// RULE15: Control bit 15 enters DC offset trim mode.
// RULE16: Reference bits 8:0 hold reference ratio, reset 80.
// RULE17: Reference bits 10:9 select lock indicator source.
// RULE18: Reference bits 13:11 are charge-pump test controls.
// RULE19: Host writes reference bit 14 as one.
// RULE20: Host writes reference bit 15 as zero.
// RULE21: Serial word is 20 bits MSB first, 16 data then 4 address.
// RULE22: Shift on rising serial clock while select low; latch on select rising.
// RULE23: Idle pin low in run turns transmit chain off; filter follows hold bit.
// RULE24: Words with unknown address are discarded.
`ifndef TX_MOD_DEFS_VH
`define TX_MOD_DEFS_VH

`define WORD_BITS      20
`define DATA_BITS      16
`define ADDR_BITS      4

`define ADDR_REF_DIV   4'h0
`define ADDR_MAIN_DIV  4'h2
`define ADDR_OP_CTRL   4'h4

`define RST_MAIN_DIV   16'h2616
`define RST_REF_DIV    16'h4050
`define RST_OP_CTRL    16'h197d

// Control fields
`define OC_RUN         0
`define OC_HOLD        1
`define OC_FILT        3
`define OC_PLL         4
`define OC_VCO         5
`define OC_TX          6
`define OC_DBL         7
`define OC_MPL         8
`define OC_PRD         9
`define OC_OUTB        10
`define OC_CP_HI       12
`define OC_CP_LO       11
`define OC_AML_HI      14
`define OC_AML_LO      13
`define OC_TRIM        15

// Reference divider fields
`define RD_RATIO_HI    8
`define RD_LD_HI       10
`define RD_LD_LO       9
`define RD_CPT_HI      13
`define RD_CPT_LO      11

`define LD_LOCK        2'h0
`define LD_MAIN        2'h1
`define LD_REF         2'h2

`define RATIO_W        9
`endif

// file: rtl/serial_shifter.v
// Serial receiver: samples the 3-wire pins on the system clock.
// Assumes serial clock far slower than clk_i (bench 800 ns vs 100 ns).
`timescale 1ns/1ps
`include "tx_mod_defs.vh"

module serial_shifter #(
  parameter WORD_W = `WORD_BITS
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_b_i,
  // Serial pins, asynchronous
  input  wire              sclk_i,
  input  wire              cs_b_i,
  input  wire              sdata_i,
  // Captured word
  output reg  [WORD_W-1:0] word_o,
  output reg               word_valid_o
);

  reg [2:0]        sclk_sync;
  reg [2:0]        cs_sync;
  reg [1:0]        data_sync;
  reg [WORD_W-1:0] shreg;

  // Two-stage synchronisers; third stage for edge finding, and on select also gates the shift
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 3'h7;
      data_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk_i};
      cs_sync   <= {cs_sync[1:0], cs_b_i};
      data_sync <= {data_sync[0], sdata_i};
    end
  end

  wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire cs_rise   = cs_sync[1] & ~cs_sync[2];

  // Shift MSB first; latch pulse when select returns high
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shreg        <= {WORD_W{1'b0}};
      word_o       <= {WORD_W{1'b0}};
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= cs_rise; // RULE22
      if (cs_rise)
        word_o <= shreg; // RULE22
      if (!cs_sync[2] && sclk_rise)
        shreg <= {shreg[WORD_W-2:0], data_sync[1]}; // RULE21
    end
  end

endmodule

// file: rtl/tx_modulator_control_regs.v
// Control register bank of the transmit modulator, with derived block enables.
// Assumes the host drives the 3-wire pins; analog blocks read the enable outputs.
`timescale 1ns/1ps
`include "tx_mod_defs.vh"

module tx_modulator_control_regs (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 rst_b_i,
  // 3-wire serial bus
  input  wire                 sclk_i,
  input  wire                 cs_b_i,
  input  wire                 sdata_i,
  // Power pins, asynchronous
  input  wire                 power_off_bar_i,
  input  wire                 idle_b_i,
  // Lock sources from the synthesiser
  input  wire                 pll_locked_i,
  input  wire                 main_div_out_i,
  input  wire                 ref_div_out_i,
  // Register contents
  output reg  [15:0]          main_divider_o,
  output reg  [15:0]          reference_divider_o,
  output reg  [15:0]          operation_control_o,
  // Derived block controls
  output reg                  baseband_filter_enable_o,
  output reg                  filter_bypass_o,
  output reg                  pll_enable_o,
  output reg                  oscillator_enable_o,
  output reg                  tx_chain_enable_o,
  output reg                  ref_doubler_enable_o,
  output reg                  max_power_select_o,
  output reg                  predriver_bias_select_o,
  output reg                  output_bias_boost_o,
  output reg  [1:0]           charge_pump_current_o,
  output reg  [1:0]           offset_correction_current_o,
  output reg                  offset_trim_mode_o,
  output reg  [`RATIO_W-1:0]  ref_ratio_o,
  output reg  [2:0]           charge_pump_test_o,
  output reg                  lock_indicator_o
);

  wire [`WORD_BITS-1:0] word;
  wire                  word_valid;

  serial_shifter #(
    .WORD_W (`WORD_BITS)
  ) u_shift (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sclk_i       (sclk_i),
    .cs_b_i       (cs_b_i),
    .sdata_i      (sdata_i),
    .word_o       (word),
    .word_valid_o (word_valid)
  );

  wire [`ADDR_BITS-1:0] waddr = word[`ADDR_BITS-1:0];
  wire [`DATA_BITS-1:0] wdata = word[`WORD_BITS-1:`ADDR_BITS];

  // Address decode, used for each of the three registers
  function hit;
    input [`ADDR_BITS-1:0] a;
    input [`ADDR_BITS-1:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // Register file; unknown addresses write nothing
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_divider_o      <= `RST_MAIN_DIV; // RULE1
      reference_divider_o <= `RST_REF_DIV;  // RULE1
      operation_control_o <= `RST_OP_CTRL;  // RULE1
    end else if (word_valid) begin // RULE24
      if (hit(waddr, `ADDR_MAIN_DIV))
        main_divider_o <= wdata;
      if (hit(waddr, `ADDR_REF_DIV))
        reference_divider_o <= wdata; // RULE19
      if (hit(waddr, `ADDR_OP_CTRL))
        operation_control_o <= wdata; // RULE4
      // Any other address falls through untouched
    end
  end

  // Power pins synchronised before use
  reg [1:0] pwr_sync;
  reg [1:0] idle_sync;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_sync  <= 2'h0;
      idle_sync <= 2'h0;
    end else begin
      pwr_sync  <= {pwr_sync[0], power_off_bar_i};
      idle_sync <= {idle_sync[0], idle_b_i};
    end
  end

  // Lock sources are asynchronous to clk_i too
  reg [1:0] lock_sync;
  reg [1:0] mdiv_sync;
  reg [1:0] rdiv_sync;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_sync <= 2'h0;
      mdiv_sync <= 2'h0;
      rdiv_sync <= 2'h0;
    end else begin
      lock_sync <= {lock_sync[0], pll_locked_i};
      mdiv_sync <= {mdiv_sync[0], main_div_out_i};
      rdiv_sync <= {rdiv_sync[0], ref_div_out_i};
    end
  end

  wire [15:0] oc  = operation_control_o;
  wire [15:0] rd  = reference_divider_o;
  // Pin low wins over the run bit
  wire run        = pwr_sync[1] & oc[`OC_RUN]; // RULE2
  wire idle       = ~idle_sync[1];

  // Held copies of PLL and oscillator enable: idle freezes the states
  // they had when the idle pin fell, so later writes wait for wake-up.
  reg pll_held;
  reg vco_held;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_held <= 1'b0;
      vco_held <= 1'b0;
    end else if (!idle) begin
      pll_held <= oc[`OC_PLL];
      vco_held <= oc[`OC_VCO];
    end
  end

  reg next_filt;
  reg next_pll;
  reg next_vco;
  reg next_tx;
  // Power mode resolution
  always @* begin
    next_filt = 1'b0;
    next_pll  = 1'b0;
    next_vco  = 1'b0;
    next_tx   = 1'b0;
    if (run) begin
      if (idle) begin
        next_tx   = 1'b0;                   // RULE23
        next_filt = oc[`OC_HOLD];           // RULE3 RULE23
        next_pll  = pll_held;               // RULE23
        next_vco  = vco_held;               // RULE23
      end else begin
        next_tx   = oc[`OC_TX];             // RULE8
        next_filt = 1'b1;
        next_pll  = oc[`OC_PLL];            // RULE6
        next_vco  = oc[`OC_VCO];            // RULE7
      end
    end
  end

  reg next_ld;
  // Lock indicator source select
  always @* begin
    case (rd[`RD_LD_HI:`RD_LD_LO]) // RULE17
      `LD_LOCK: next_ld = lock_sync[1];
      `LD_MAIN: next_ld = mdiv_sync[1];
      `LD_REF:  next_ld = rdiv_sync[1];
      default:  next_ld = 1'b0;
    endcase
  end

  // Registered outputs; filter power and bypass are kept apart because
  // idle hold keeps the filter powered even if its enable bit is clear.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baseband_filter_enable_o    <= 1'b0;
      filter_bypass_o             <= 1'b0;
      pll_enable_o                <= 1'b0;
      oscillator_enable_o         <= 1'b0;
      tx_chain_enable_o           <= 1'b0;
      ref_doubler_enable_o        <= 1'b0;
      max_power_select_o          <= 1'b0;
      predriver_bias_select_o     <= 1'b0;
      output_bias_boost_o         <= 1'b0;
      charge_pump_current_o       <= 2'h0;
      offset_correction_current_o <= 2'h0;
      offset_trim_mode_o          <= 1'b0;
      ref_ratio_o                 <= {`RATIO_W{1'b0}};
      charge_pump_test_o          <= 3'h0;
      lock_indicator_o            <= 1'b0;
    end else begin
      baseband_filter_enable_o    <= next_filt;
      filter_bypass_o             <= run & ~oc[`OC_FILT];                 // RULE5
      pll_enable_o                <= next_pll;
      oscillator_enable_o         <= next_vco;
      tx_chain_enable_o           <= next_tx;
      ref_doubler_enable_o        <= run & oc[`OC_DBL];                   // RULE9
      max_power_select_o          <= oc[`OC_MPL];                         // RULE10
      predriver_bias_select_o     <= oc[`OC_PRD];                         // RULE11
      output_bias_boost_o         <= oc[`OC_OUTB];                        // RULE12
      charge_pump_current_o       <= oc[`OC_CP_HI:`OC_CP_LO];             // RULE13
      // Offset current forced off while trim bit 15 is clear; the run bit does not gate it
      offset_correction_current_o <= oc[`OC_TRIM] ? oc[`OC_AML_HI:`OC_AML_LO] : 2'h0; // RULE14
      offset_trim_mode_o          <= run & oc[`OC_TRIM];                  // RULE15
      ref_ratio_o                 <= rd[`RD_RATIO_HI:0];                  // RULE16
      charge_pump_test_o          <= rd[`RD_CPT_HI:`RD_CPT_LO];           // RULE18
      lock_indicator_o            <= next_ld;
    end
  end

endmodule

// file: test/tx_mod_regs_asserts.sv
// Checker for the modulator control bank, bound to its top ports.
// Assumes every derived output is registered one cycle after its source.
`timescale 1ns/1ps
module tx_mod_regs_asserts (
  // Clock, reset and pins
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        cs_b_i,
  input wire        power_off_bar_i,
  input wire        idle_b_i,
  // Registers
  input wire [15:0] main_divider_o,
  input wire [15:0] reference_divider_o,
  input wire [15:0] operation_control_o,
  // Derived controls
  input wire        baseband_filter_enable_o,
  input wire        pll_enable_o,
  input wire        tx_chain_enable_o,
  input wire        ref_doubler_enable_o,
  input wire        max_power_select_o,
  input wire        predriver_bias_select_o,
  input wire        output_bias_boost_o,
  input wire [1:0]  charge_pump_current_o,
  input wire [1:0]  offset_correction_current_o,
  input wire        lock_indicator_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Short names keep the properties on one line
  wire [15:0] oc = operation_control_o;
  wire [15:0] rd = reference_divider_o;
  wire        all_on = tx_chain_enable_o | pll_enable_o | baseband_filter_enable_o;

  a_reset_values: assert property (
    $rose(rst_b_i) |-> main_divider_o == 16'h2616 && rd == 16'h4050 && oc == 16'h197d) else $error("bad default");
  a_run_off: assert property (
    !oc[0] [*2] |-> !all_on) else $error("block on with run low");
  a_pin_off: assert property (
    !power_off_bar_i [*5] |-> !all_on) else $error("block on with pin low");
  a_pll_off: assert property (
    (idle_b_i && !oc[4]) [*6] |-> !pll_enable_o) else $error("pll on");
  a_idle_tx: assert property (
    !idle_b_i [*5] |-> !tx_chain_enable_o) else $error("tx on in idle");
  a_idle_filter: assert property (
    (!idle_b_i && !oc[1]) [*5] |-> !baseband_filter_enable_o) else $error("filter on in idle");
  a_doubler_source: assert property (
    ref_doubler_enable_o |-> $past(oc[7])) else $error("doubler on");
  a_trim_current: assert property (
    offset_correction_current_o != 2'h0 |-> $past(oc[15]) && offset_correction_current_o == $past(oc[14:13]))
    else $error("offset current wrong");
  a_ctrl_fields: assert property (
    rst_b_i && $stable(oc) |=> {charge_pump_current_o, output_bias_boost_o, predriver_bias_select_o, max_power_select_o}
      == $past(oc[12:8])) else $error("control field wrong");
  a_lock_low: assert property (
    (rd[10:9] == 2'h3) [*3] |-> !lock_indicator_o) else $error("lock not low");
  a_write_quiet: assert property (
    $changed(oc) || $changed(rd) || $changed(main_divider_o) |-> $past(cs_b_i) && $past(cs_b_i, 3))
    else $error("register moved in frame");
  // Main scenarios
  cover property (!power_off_bar_i [*5]);
  cover property ($changed(rd));
  cover property (!idle_b_i && oc[1]);
endmodule

bind tx_modulator_control_regs tx_mod_regs_asserts chk_u (.clk_i, .rst_b_i, .cs_b_i, .power_off_bar_i, .idle_b_i,
  .main_divider_o, .reference_divider_o, .operation_control_o, .baseband_filter_enable_o, .pll_enable_o,
  .tx_chain_enable_o, .ref_doubler_enable_o, .max_power_select_o, .predriver_bias_select_o,
  .output_bias_boost_o, .charge_pump_current_o, .offset_correction_current_o, .lock_indicator_o);

// file: test/host_3wire.sv
// Host side of the 3-wire bus: shifts 20-bit words into the bank.
// Assumes one caller at a time; pins move on rising clk_i edges.
`timescale 1ns/1ps
module host_3wire (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      sdata_o
);
  // Serial clock rests low and select high outside frames
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdata_o = 1'b0;
  end
  // Data moves while the clock is low; 800 ns serial period
  task send(input logic [19:0] w);
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    for (int i = 19; i >= 0; i--) begin
      sdata_o <= w[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    cs_b_o <= 1'b1;
    sdata_o <= ~w[0]; // No pull on data: stale level must not help
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// file: test/tx_modulator_control_regs_tb_top.sv
// Self-checking bench for the modulator control bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tx_modulator_control_regs_tb_top;
  logic        clk_i = 0, rst_b_i = 0, pwr_b = 1, idle_b = 1;
  logic [2:0]  src = 0;
  logic [15:0] w, rw;
  logic [15:0] ow [5] = '{16'h0004, 16'ha8d5, 16'hd77d, 16'hffff, 16'h197d};
  logic [2:0]  ct [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6};
  logic [3:0]  bad [3] = '{4'h8, 4'hc, 4'h3};
  wire         sclk, cs_b, sdata, fen, byp, pll, vco, tx, dbl, max_power_select, prd, obb, trim, lock;
  wire [15:0]  md, rd, oc;
  wire [8:0]   ratio;
  wire [2:0]   cpt;
  wire [1:0]   cp, aml;
  int          err_total = 0, cmp_count = 0;

  always #50 clk_i = ~clk_i;
  host_3wire host_u (.clk_i, .sclk_o(sclk), .cs_b_o(cs_b), .sdata_o(sdata));
  tx_modulator_control_regs dut_u (.clk_i, .rst_b_i, .sclk_i(sclk), .cs_b_i(cs_b), .sdata_i(sdata),
    .power_off_bar_i(pwr_b), .idle_b_i(idle_b), .pll_locked_i(src[0]), .main_div_out_i(src[1]),
    .ref_div_out_i(src[2]), .main_divider_o(md), .reference_divider_o(rd), .operation_control_o(oc),
    .baseband_filter_enable_o(fen), .filter_bypass_o(byp), .pll_enable_o(pll), .oscillator_enable_o(vco),
    .tx_chain_enable_o(tx), .ref_doubler_enable_o(dbl), .max_power_select_o(max_power_select),
    .predriver_bias_select_o(prd), .output_bias_boost_o(obb), .charge_pump_current_o(cp),
    .offset_correction_current_o(aml), .offset_trim_mode_o(trim), .ref_ratio_o(ratio),
    .charge_pump_test_o(cpt), .lock_indicator_o(lock));

  // Compare and count
  task chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    tick(20000);
    err_total++;
    test_done;
  end

  // Main sequence; each frame ends well past the five-edge write delay
  initial begin
    tick(3);
    rst_b_i <= 1;
    tick(1);
    chk(md, 16'h2616);
    chk(rd, 16'h4050);
    chk(oc, 16'h197d);
    tick(6);
    chk({tx, vco, pll, fen, byp}, 5'h1e);
    foreach (ow[i]) begin
      w = ow[i];
      host_u.send({w, 4'h4});
      chk(oc, w);
      chk({tx, vco, pll, byp}, {w[0] & w[6], w[0] & w[5], w[0] & w[4], w[0] & ~w[3]});
      chk({cp, obb, prd, max_power_select}, w[12:8]);
      chk({trim, dbl, aml}, {w[0] & w[15], w[0] & w[7], w[15] ? w[14:13] : 2'h0});
    end
    foreach (ct[i]) begin
      w = {2'b01, ct[i], 2'(i % 4), 9'(i * 37 + 3)};
      host_u.send({w, 4'h0});
      chk({cpt, ratio}, {w[13:11], w[8:0]});
      for (int k = 0; k < 3; k++) begin
        src <= 3'(1 << k);
        tick(5);
        chk(lock, (i % 4) == k);
      end
    end
    rw = w;
    host_u.send({16'h9c35, 4'h2});
    chk(md, 16'h9c35);
    // Aliases of the valid addresses must still be ignored
    foreach (bad[i]) begin
      host_u.send({16'h0bad, bad[i]});
      chk(md, 16'h9c35);
      chk(rd, rw);
      chk(oc, 16'h197d);
    end
    idle_b <= 0;
    tick(6);
    chk({tx, vco, pll, fen}, 4'h6);
    idle_b <= 1;
    host_u.send({16'h197f, 4'h4});
    idle_b <= 0;
    tick(6);
    chk({tx, vco, pll, fen}, 4'h7);
    // PLL bit cleared while idle: enables stay frozen until wake-up
    host_u.send({16'h196f, 4'h4});
    chk(oc, 16'h196f);
    chk({tx, vco, pll, fen}, 4'h7);
    idle_b <= 1;
    tick(6);
    chk({tx, vco, pll, fen}, 4'hd);
    pwr_b <= 0;
    tick(6);
    chk({tx, vco, pll, fen}, 4'h0);
    chk(oc, 16'h196f);
    test_done;
  end
endmodule
